// ===== rtl/uifc_defs.svh
`ifndef UIFC_DEFS_SVH
`define UIFC_DEFS_SVH
// Register addresses (A2..A0)
`define UIFC_ADDR_RX_HOLDING   3'h0
`define UIFC_ADDR_TX_HOLDING   3'h0
`define UIFC_ADDR_INT_ENABLE   3'h1
`define UIFC_ADDR_INT_STATUS   3'h2
`define UIFC_ADDR_FIFO_CONTROL 3'h2
`define UIFC_ADDR_LINE_STATUS  3'h5
`define UIFC_ADDR_MODEM_STATUS 3'h6
// Interrupt enable fields
`define UIFC_IE_RX      0
`define UIFC_IE_TX      1
`define UIFC_IE_LINE    2
`define UIFC_IE_MODEM   3
`define UIFC_IE_XOFF    5
`define UIFC_IE_RTS     6
`define UIFC_IE_CTS     7
`define UIFC_IE_BASIC_MASK 8'h0F
// FIFO control fields
`define UIFC_FC_ENABLE  0
`define UIFC_FC_RXRST   1
`define UIFC_FC_TXRST   2
`define UIFC_FC_DMA     3
// Status codes, bits 5..0
`define UIFC_CODE_LINE  6'h06
`define UIFC_CODE_RXTO  6'h0C
`define UIFC_CODE_RX_READY_PIN_N 6'h04
`define UIFC_CODE_TX_READY_PIN_N 6'h02
`define UIFC_CODE_MODEM 6'h00
`define UIFC_CODE_XOFF  6'h10
`define UIFC_CODE_FLOW  6'h20
`define UIFC_CODE_NONE  6'h01
// Reset values
`define UIFC_RESET_BYTE 8'h00
// Timeout: four characters plus twelve bit times
`define UIFC_TO_CHARS   4
`define UIFC_TO_BITS    12
`define UIFC_BITS_PER_CHAR 10
`endif

// ===== rtl/uifc_pkg.sv
package uifc_pkg;
   typedef logic [7:0] uifc_byte_t;
   typedef logic [5:0] uifc_count_t;
   typedef enum logic [2:0] {
      UIFC_SRC_NONE  = 3'b000,
      UIFC_SRC_LINE  = 3'b001,
      UIFC_SRC_RXTO  = 3'b010,
      UIFC_SRC_RX_READY_PIN_N = 3'b011,
      UIFC_SRC_TX_READY_PIN_N = 3'b100,
      UIFC_SRC_MODEM = 3'b101,
      UIFC_SRC_XOFF  = 3'b110,
      UIFC_SRC_FLOW  = 3'b111
   } uifc_src_t;
endpackage : uifc_pkg

// ===== rtl/uifc_uart_interrupt_fifo_control.sv
`timescale 1ns/1ps
`include "uifc_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Transmit ready interrupt on holding empty or TX FIFO below trigger.
// - Line status bits 1-4 interrupt; overrun at once, others on readout.
// - Modem status bits 0-3 interrupt when enable bit 3 set.
// - Enable bits 4-7 writable only with enhanced-function bit set.
// - Interrupt on rising RTS output or CTS input under auto flow.
// - Status read reports only top pending source; others stay queued.
// - Codes: line 06, timeout 0C, data 04, transmit 02, modem 00.
// - Codes: Xoff/special 10, flow pin 20, none 01 (default).
// - Receive timeout after four characters plus twelve bit times.
// - Receive data interrupt follows trigger; clears below trigger.
// - Transmit interrupt cleared by status read or holding write.
// - Line interrupt cleared by line status read.
// - Modem status read clears modem and flow-pin interrupts.
// - Timeout interrupt cleared by receive holding read.
// - Xoff cleared by status read or Xon; special by next character.
// - Status bit 0 low while pending, high when idle.
// - Status bits 4,5 active only with enhanced-function bit.
// - Status bits 7:6 read 11 with FIFOs enabled, else 00.
// - FIFO control bit 0 enables FIFOs; must be set to program others.
// - Bit 1 resets RX FIFO pointers when enabled, self-clears.
// - Bit 2 resets TX FIFO pointers when enabled, self-clears.
// - Bit 3 selects DMA mode for ready pins.
// - TX trigger needs enhanced bit; below trigger, or empty if unfilled.
// - Two-bit RX trigger field sets receive level, default 0.
// - Receive data interrupt on holding full or FIFO at trigger.
// - Interrupt driven only with output-enable bit; gp output inverted.
module uifc_uart_interrupt_fifo_control #(
   parameter int unsigned BAUD_DIV  = 16,
   parameter int unsigned RX_TRIG0  = 8,
   parameter int unsigned RX_TRIG1  = 16,
   parameter int unsigned RX_TRIG2  = 24,
   parameter int unsigned RX_TRIG3  = 28,
   parameter int unsigned TX_TRIG0  = 16,
   parameter int unsigned TX_TRIG1  = 8,
   parameter int unsigned TX_TRIG2  = 24,
   parameter int unsigned TX_TRIG3  = 30
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   input  wire logic [2:0]        addr,
   input  wire logic              rdStb,
   input  wire logic              wrStb,
   input  wire uifc_pkg::uifc_byte_t wrData,
   input  wire logic              enhancedEn,
   input  wire logic              autoRtsEn,
   input  wire logic              autoCtsEn,
   input  wire logic              intOutEn,
   input  wire uifc_pkg::uifc_byte_t lineStatus,
   input  wire logic              lineErrAtHead,
   input  wire logic              overrunEvt,
   input  wire logic [3:0]        modemDelta,
   input  wire uifc_pkg::uifc_count_t rxCount,
   input  wire uifc_pkg::uifc_count_t txCount,
   input  wire logic              rxCharEvt,
   input  wire logic              xoffEvt,
   input  wire logic              xonEvt,
   input  wire logic              specialEvt,
   input  wire logic              rtsOut,
   input  wire logic              ctsIn,
   output logic                   intOut,
   output logic                   intOutOe,
   output logic                   gpOutputTwo_n,
   output uifc_pkg::uifc_byte_t   rdData,
   output logic                   fifoEn,
   output logic                   dmaMode,
   output logic                   rxFifoRst,
   output logic                   txFifoRst,
   output logic [1:0]             rxTrigSel,
   output logic [1:0]             txTrigSel
);
   import uifc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Timeout length in reference clocks
   localparam int unsigned TO_BITS =
      `UIFC_TO_CHARS * `UIFC_BITS_PER_CHAR + `UIFC_TO_BITS;
   localparam int unsigned TO_CYC = TO_BITS * BAUD_DIV;
   localparam int unsigned TO_W   = $clog2(TO_CYC + 1);

   function automatic uifc_count_t trigLevel(input logic [1:0] sel,
                                             input logic       isRx);
      int unsigned v;
      v = 0;
      unique case (sel)
         2'b00: v = isRx ? RX_TRIG0 : TX_TRIG0;
         2'b01: v = isRx ? RX_TRIG1 : TX_TRIG1;
         2'b10: v = isRx ? RX_TRIG2 : TX_TRIG2;
         2'b11: v = isRx ? RX_TRIG3 : TX_TRIG3;
      endcase
      return uifc_count_t'(v);
   endfunction : trigLevel

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   uifc_byte_t  intEnable_q, intEnable_d;
   logic        fifoEn_q, dmaMode_q, rxRst_q, txRst_q;
   logic [1:0]  rxTrig_q, txTrig_q;
   logic        lineInt_q, txInt_q, toInt_q, modemInt_q;
   logic        xoffInt_q, specInt_q, flowInt_q, txFilled_q;
   logic        rtsOut_q, ctsIn_q, txEmptyPrev_q, txEnPrev_q;
   logic [TO_W-1:0] toCnt_q;
   uifc_byte_t  rdData_q;
   logic        intOut_q, intOutOe_q, gpOut_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire rdRx    = rdStb && addr == `UIFC_ADDR_RX_HOLDING;
   wire rdIsr   = rdStb && addr == `UIFC_ADDR_INT_STATUS;
   wire rdLsr   = rdStb && addr == `UIFC_ADDR_LINE_STATUS;
   wire rdMsr   = rdStb && addr == `UIFC_ADDR_MODEM_STATUS;
   wire wrTx    = wrStb && addr == `UIFC_ADDR_TX_HOLDING;
   wire wrIer   = wrStb && addr == `UIFC_ADDR_INT_ENABLE;
   wire wrFcr   = wrStb && addr == `UIFC_ADDR_FIFO_CONTROL;
   wire fcrTake = wrFcr && wrData[`UIFC_FC_ENABLE];

   ////////////////////////////////////////////////////////////////////////////
   // Source conditions
   wire uifc_count_t rxLvl = trigLevel(rxTrig_q, 1'b1);
   wire uifc_count_t txLvl = trigLevel(txTrig_q, 1'b0);
   // Holding register treated as a FIFO of one when disabled
   wire rxAtTrig  = fifoEn_q ? (rxCount >= rxLvl)
                             : (rxCount != 6'h00);
   wire txEmpty   = txCount == 6'h00;
   wire txBelow   = fifoEn_q ? (txCount < txLvl) : txEmpty;
   // Empty still counts when the last reload never passed the trigger
   wire txCond    = txBelow && (txFilled_q || txEmpty || !fifoEn_q);
   wire txEnRise  = intEnable_q[`UIFC_IE_TX] && !txEnPrev_q;
   wire txSet     = (txCond && !txEmptyPrev_q) || (txEnRise && txCond);
   wire lineSet   = overrunEvt || lineErrAtHead;
   wire rtsRise   = autoRtsEn && rtsOut && !rtsOut_q;
   wire ctsRise   = autoCtsEn && ctsIn && !ctsIn_q;
   wire toHit     = toCnt_q == TO_W'(TO_CYC);

   wire pLine  = intEnable_q[`UIFC_IE_LINE] && lineInt_q;
   wire pRxTo  = intEnable_q[`UIFC_IE_RX] && toInt_q;
   wire pRx    = intEnable_q[`UIFC_IE_RX] && rxAtTrig;
   wire pTx    = intEnable_q[`UIFC_IE_TX] && txInt_q;
   wire pModem = intEnable_q[`UIFC_IE_MODEM] && modemInt_q;
   wire pXoff  = enhancedEn && intEnable_q[`UIFC_IE_XOFF]
                 && (xoffInt_q || specInt_q);
   wire pFlow  = enhancedEn && flowInt_q;

   // Fixed priority, only the winner is reported
   wire uifc_src_t topSrc =
      pLine  ? UIFC_SRC_LINE  :
      pRxTo  ? UIFC_SRC_RXTO  :
      pRx    ? UIFC_SRC_RX_READY_PIN_N :
      pTx    ? UIFC_SRC_TX_READY_PIN_N :
      pModem ? UIFC_SRC_MODEM :
      pXoff  ? UIFC_SRC_XOFF  :
      pFlow  ? UIFC_SRC_FLOW  : UIFC_SRC_NONE;

   logic [5:0] srcCode;
   always_comb begin
      unique case (topSrc)
         UIFC_SRC_LINE:  srcCode = `UIFC_CODE_LINE;
         UIFC_SRC_RXTO:  srcCode = `UIFC_CODE_RXTO;
         UIFC_SRC_RX_READY_PIN_N: srcCode = `UIFC_CODE_RX_READY_PIN_N;
         UIFC_SRC_TX_READY_PIN_N: srcCode = `UIFC_CODE_TX_READY_PIN_N;
         UIFC_SRC_MODEM: srcCode = `UIFC_CODE_MODEM;
         UIFC_SRC_XOFF:  srcCode = `UIFC_CODE_XOFF;
         UIFC_SRC_FLOW:  srcCode = `UIFC_CODE_FLOW;
         UIFC_SRC_NONE:  srcCode = `UIFC_CODE_NONE;
      endcase
   end

   wire uifc_byte_t isrByte = {{2{fifoEn_q}}, srcCode};
   wire uifc_byte_t ierRead = intEnable_q;
   wire uifc_byte_t rdNext  =
      rdIsr ? isrByte :
      (rdStb && addr == `UIFC_ADDR_INT_ENABLE) ? ierRead : `UIFC_RESET_BYTE;
   // Reading status acknowledges the reported source only if it is transmit or Xoff/special
   wire ackTx   = rdIsr && topSrc == UIFC_SRC_TX_READY_PIN_N;
   wire ackXoff = rdIsr && topSrc == UIFC_SRC_XOFF;

   always_comb begin
      intEnable_d = intEnable_q;
      if (wrIer) begin
         intEnable_d = enhancedEn ? wrData
                     : ((intEnable_q & ~`UIFC_IE_BASIC_MASK)
                        | (wrData & `UIFC_IE_BASIC_MASK));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         intEnable_q <= `UIFC_RESET_BYTE;
      end else begin
         intEnable_q <= intEnable_d;
      end
   end

   // Writing bit 0 low still turns the FIFOs off
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         fifoEn_q <= 1'b0;
      end else if (wrFcr) begin
         fifoEn_q <= wrData[`UIFC_FC_ENABLE];
      end
   end

   // Pointer resets last one cycle, then clear themselves
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rxRst_q <= 1'b0;
         txRst_q <= 1'b0;
      end else begin
         rxRst_q <= fcrTake && wrData[`UIFC_FC_RXRST];
         txRst_q <= fcrTake && wrData[`UIFC_FC_TXRST];
      end
   end

   // A write without bit 0 leaves the other fields untouched
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         dmaMode_q <= 1'b0;
         rxTrig_q  <= 2'b00;
      end else if (fcrTake) begin
         dmaMode_q <= wrData[`UIFC_FC_DMA];
         rxTrig_q  <= wrData[7:6];
      end
   end

   // TX trigger field needs the enhanced-function bit
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txTrig_q <= 2'b00;
      end else if (fcrTake && enhancedEn) begin
         txTrig_q <= wrData[5:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky sources; a set in the clearing cycle wins
   wire lineInt_d  = lineSet || (lineInt_q && !rdLsr);
   wire txInt_d    = txSet || (txInt_q && !ackTx && !wrTx);
   wire toInt_d    = toHit || (toInt_q && !rdRx);
   wire modemInt_d = (|modemDelta) || (modemInt_q && !rdMsr);
   wire xoffInt_d  = xoffEvt || (xoffInt_q && !ackXoff && !xonEvt);
   wire specInt_d  = specialEvt
                     || (specInt_q && !ackXoff && !rxCharEvt);
   // Flow edges are only latched while their enable bit is set
   wire flowInt_d  = (rtsRise && intEnable_q[`UIFC_IE_RTS])
                     || (ctsRise && intEnable_q[`UIFC_IE_CTS])
                     || (flowInt_q && !rdMsr);

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         lineInt_q <= 1'b0;
      end else begin
         lineInt_q <= lineInt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txInt_q <= 1'b0;
      end else begin
         txInt_q <= txInt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         toInt_q <= 1'b0;
      end else begin
         toInt_q <= toInt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         modemInt_q <= 1'b0;
      end else begin
         modemInt_q <= modemInt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         xoffInt_q <= 1'b0;
      end else begin
         xoffInt_q <= xoffInt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         specInt_q <= 1'b0;
      end else begin
         specInt_q <= specInt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         flowInt_q <= 1'b0;
      end else begin
         flowInt_q <= flowInt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge history, timeout timer and outputs
   // Pin and TX-empty history starts high so a pin already high at reset raises no false edge; TX enable history starts low
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rtsOut_q      <= 1'b1;
         ctsIn_q       <= 1'b1;
         txEmptyPrev_q <= 1'b1;
         txEnPrev_q    <= 1'b0;
      end else begin
         rtsOut_q      <= rtsOut;
         ctsIn_q       <= ctsIn;
         txEmptyPrev_q <= txBelow;
         txEnPrev_q    <= intEnable_q[`UIFC_IE_TX];
      end
   end

   // Remembers whether the last reload passed the TX trigger
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         txFilled_q <= 1'b0;
      end else if (txCount > txLvl) begin
         txFilled_q <= 1'b1;
      end else if (txEmpty) begin
         txFilled_q <= 1'b0;
      end
   end

   // Restarts on any receive or receive holding read; idles when RX is empty
   wire toRestart = rxCharEvt || rdRx || rxCount == 6'h00 || toHit;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         toCnt_q <= '0;
      end else if (toRestart) begin
         toCnt_q <= '0;
      end else begin
         toCnt_q <= toCnt_q + TO_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rdData_q <= `UIFC_RESET_BYTE;
      end else begin
         rdData_q <= rdNext;
      end
   end

   // Pin outputs registered so the enable and level change together
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         intOut_q   <= 1'b0;
         intOutOe_q <= 1'b0;
         gpOut_q    <= 1'b1;
      end else begin
         intOut_q   <= intOutEn && (topSrc != UIFC_SRC_NONE);
         intOutOe_q <= intOutEn;
         gpOut_q    <= !intOutEn;
      end
   end

   assign intOut        = intOut_q;
   assign intOutOe      = intOutOe_q;
   assign gpOutputTwo_n = gpOut_q;
   assign rdData        = rdData_q;
   assign fifoEn        = fifoEn_q;
   assign dmaMode       = dmaMode_q;
   assign rxFifoRst     = rxRst_q;
   assign txFifoRst     = txRst_q;
   assign rxTrigSel     = rxTrig_q;
   assign txTrigSel     = txTrig_q;

endmodule : uifc_uart_interrupt_fifo_control

// ===== bench/uifc_checker_sva.sv
`timescale 1ns/1ps
module uifc_checker (
   input wire logic                 ref_clk,
   input wire logic                 rst_b,
   input wire logic [2:0]           addr,
   input wire logic                 rdStb,
   input wire logic                 wrStb,
   input wire uifc_pkg::uifc_byte_t wrData,
   input wire logic                 enhancedEn,
   input wire logic                 intOutEn,
   input wire logic                 intOut,
   input wire logic                 intOutOe,
   input wire logic                 gpOutputTwo_n,
   input wire uifc_pkg::uifc_byte_t rdData,
   input wire logic                 fifoEn,
   input wire logic                 dmaMode,
   input wire logic                 rxFifoRst,
   input wire logic                 txFifoRst,
   input wire logic [1:0]           rxTrigSel,
   input wire logic [1:0]           txTrigSel
);
   import uifc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire fcWr  = wrStb && addr == 3'h2;
   wire isrRd = rdStb && addr == 3'h2;
   ////////////////////////////////////////////////////////////////////////////
   pin_follow_a: assert property (
      1 |=> gpOutputTwo_n == !$past(intOutEn) && intOutOe == $past(intOutEn))
      else $error("interrupt pin enable wrong");
   fifo_flag_a: assert property (
      isrRd |=> rdData[7:6] == {2{$past(fifoEn)}})
      else $error("fifo status bits wrong");
   legal_code_a: assert property (
      isrRd |=> rdData[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00,
                                    6'h10, 6'h20, 6'h01})
      else $error("illegal status code");
   rx_reset_a: assert property (
      fcWr && wrData[0] && wrData[1] |=> rxFifoRst
         ##1 (!rxFifoRst || $past(fcWr && wrData[0] && wrData[1])))
      else $error("rx fifo reset pulse wrong");
   tx_reset_a: assert property (
      fcWr && wrData[0] && wrData[2] |=> txFifoRst
         ##1 (!txFifoRst || $past(fcWr && wrData[0] && wrData[2])))
      else $error("tx fifo reset pulse wrong");
   no_program_a: assert property (
      fcWr && !wrData[0] |=> !fifoEn && !rxFifoRst && !txFifoRst
         && $stable(dmaMode) && $stable(rxTrigSel))
      else $error("fifo control taken without enable");
   fc_program_a: assert property (
      fcWr && wrData[0] |=> fifoEn && dmaMode == $past(wrData[3])
         && rxTrigSel == $past(wrData[7:6]))
      else $error("fifo control fields wrong");
   tx_trig_a: assert property (
      fcWr && wrData[0] |=> txTrigSel == ($past(enhancedEn) ?
         $past(wrData[5:4]) : $past(txTrigSel)))
      else $error("tx trigger field wrong");
   cover property (isrRd ##1 rdData[5:0] == 6'h0C);
   cover property (rxFifoRst);
   cover property (intOut && intOutOe);
endmodule : uifc_checker
bind uifc_uart_interrupt_fifo_control uifc_checker u_chk (.ref_clk, .rst_b,
   .addr, .rdStb, .wrStb, .wrData, .enhancedEn, .intOutEn, .intOut,
   .intOutOe, .gpOutputTwo_n, .rdData, .fifoEn, .dmaMode, .rxFifoRst,
   .txFifoRst, .rxTrigSel, .txTrigSel);

// ===== bench/uifc_host_model.sv
`timescale 1ns/1ps
module uifc_host_model (
   input  wire logic                 ref_clk,
   output logic [2:0]                addr,
   output logic                      rdStb,
   output logic                      wrStb,
   output uifc_pkg::uifc_byte_t      wrData,
   input  wire uifc_pkg::uifc_byte_t rdData
);
   import uifc_pkg::*;
   initial begin
      addr = 3'h7;
      rdStb = 1'h0;
      wrStb = 1'h0;
      wrData = 8'hA5;
   end
   // Idle bus shows inverted values so stale data is never mistaken
   task automatic xfer(input logic w, input logic [2:0] a,
                       input uifc_byte_t d, output uifc_byte_t q);
      @(posedge ref_clk);
      #1;
      addr = a;
      wrData = d;
      rdStb = !w;
      wrStb = w;
      @(posedge ref_clk);
      #1;
      rdStb = 1'h0;
      wrStb = 1'h0;
      addr = ~a;
      wrData = ~d;
      q = rdData;
   endtask : xfer
endmodule : uifc_host_model

// ===== bench/uifc_uart_interrupt_fifo_control_tb.sv
`timescale 1ns/1ps
module uifc_uart_interrupt_fifo_control_tb;
   import uifc_pkg::*;
   logic ref_clk = 1'h0, rst_b = 1'h0, enhancedEn = 1'h0, autoRtsEn = 1'h0;
   logic autoCtsEn = 1'h0, intOutEn = 1'h0, lineErrAtHead = 1'h0;
   logic overrunEvt = 1'h0, rxCharEvt = 1'h0, xoffEvt = 1'h0, xonEvt = 1'h0;
   logic specialEvt = 1'h0, rtsOut = 1'h0, ctsIn = 1'h0, rdStb, wrStb;
   logic [2:0] addr;
   logic [3:0] modemDelta = 4'h0;
   uifc_byte_t wrData, rdData, lineStatus = 8'h00;
   uifc_count_t rxCount = 6'h00, txCount = 6'h05;
   logic intOut, intOutOe, gpOutputTwo_n, fifoEn, dmaMode, rxFifoRst;
   logic txFifoRst;
   logic [1:0] rxTrigSel, txTrigSel;
   int fails = 0, checkCount = 0;
   uifc_uart_interrupt_fifo_control #(.BAUD_DIV(1)) dut (.ref_clk, .rst_b,
      .addr, .rdStb, .wrStb, .wrData, .enhancedEn, .autoRtsEn, .autoCtsEn,
      .intOutEn, .lineStatus, .lineErrAtHead, .overrunEvt, .modemDelta,
      .rxCount, .txCount, .rxCharEvt, .xoffEvt, .xonEvt, .specialEvt, .rtsOut,
      .ctsIn, .intOut, .intOutOe, .gpOutputTwo_n, .rdData, .fifoEn, .dmaMode,
      .rxFifoRst, .txFifoRst, .rxTrigSel, .txTrigSel);
   uifc_host_model host (.ref_clk, .addr, .rdStb, .wrStb, .wrData, .rdData);
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : cyc
   task automatic pls(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
   endtask : pls
   task automatic wr(input logic [2:0] a, input uifc_byte_t d);
      uifc_byte_t q;
      host.xfer(1'h1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [2:0] a, input uifc_byte_t e);
      uifc_byte_t q;
      host.xfer(1'h0, a, 8'h00, q);
      chk(q, e);
   endtask : rdc
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_prio;
      wr(3'h1, 8'hFF);
      rdc(3'h1, 8'h0F);
      modemDelta = 4'h4;
      cyc(1);
      modemDelta = 4'h0;
      rdc(3'h2, 8'h00);
      pls(overrunEvt);
      rdc(3'h2, 8'h06);
      rdc(3'h5, 8'h00);
      rdc(3'h2, 8'h00);
      pls(lineErrAtHead);
      rdc(3'h2, 8'h06);
      rdc(3'h5, 8'h00);
      rdc(3'h6, 8'h00);
      rdc(3'h2, 8'h01);
   endtask : t_prio
   task automatic t_tx;
      wr(3'h1, 8'h00);
      txCount = 6'h00;
      // Holding write clears the pending flag, so only the enable can raise it
      wr(3'h0, 8'h5A);
      wr(3'h1, 8'h02);
      rdc(3'h2, 8'h02);
      rdc(3'h2, 8'h01);
      txCount = 6'h01;
      cyc(1);
      txCount = 6'h00;
      rdc(3'h2, 8'h02);
      wr(3'h0, 8'h5A);
      rdc(3'h2, 8'h01);
      wr(3'h1, 8'h00);
   endtask : t_tx
   task automatic t_fifo;
      wr(3'h2, 8'h07);
      chk({6'h00, rxFifoRst, txFifoRst}, 8'h03);
      rdc(3'h2, 8'hC1);
      chk({6'h00, rxFifoRst, txFifoRst}, 8'h00);
      wr(3'h2, 8'hC9);
      chk({fifoEn, dmaMode, rxTrigSel, 4'h0}, 8'hF0);
      wr(3'h2, 8'h36);
      chk({fifoEn, dmaMode, txTrigSel, 4'h0}, 8'h40);
      rdc(3'h2, 8'h01);
      enhancedEn = 1'h1;
      wr(3'h2, 8'h31);
      chk({fifoEn, dmaMode, txTrigSel, rxTrigSel, 2'h0}, 8'hB0);
      enhancedEn = 1'h0;
   endtask : t_fifo
   task automatic t_rx;
      wr(3'h1, 8'h01);
      rxCount = 6'h08;
      rdc(3'h2, 8'hC4);
      rxCount = 6'h07;
      rdc(3'h2, 8'hC1);
      cyc(44);
      rdc(3'h2, 8'hC1);
      cyc(14);
      rdc(3'h2, 8'hCC);
      rdc(3'h0, 8'h00);
      rdc(3'h2, 8'hC1);
      rxCount = 6'h00;
   endtask : t_rx
   task automatic t_flow;
      enhancedEn = 1'h1;
      wr(3'h1, 8'hE0);
      pls(xoffEvt);
      rdc(3'h2, 8'hD0);
      rdc(3'h2, 8'hC1);
      pls(xoffEvt);
      pls(xonEvt);
      rdc(3'h2, 8'hC1);
      pls(specialEvt);
      pls(rxCharEvt);
      rdc(3'h2, 8'hC1);
      autoRtsEn = 1'h1;
      autoCtsEn = 1'h1;
      rtsOut = 1'h1;
      rdc(3'h2, 8'hE0);
      rdc(3'h2, 8'hE0);
      rdc(3'h6, 8'h00);
      rdc(3'h2, 8'hC1);
      ctsIn = 1'h1;
      rdc(3'h2, 8'hE0);
      rdc(3'h6, 8'h00);
      rdc(3'h2, 8'hC1);
      intOutEn = 1'h1;
      pls(xoffEvt);
      cyc(1);
      chk({intOutOe, gpOutputTwo_n, intOut, 5'h00}, 8'hA0);
      rdc(3'h2, 8'hD0);
      cyc(1);
      chk(8'(intOut), 8'h00);
      enhancedEn = 1'h0;
      pls(xoffEvt);
      rdc(3'h2, 8'hC1);
   endtask : t_flow
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      rst_b = 1'h1;
      rdc(3'h2, 8'h01);
      rdc(3'h1, 8'h00);
      t_prio();
      t_tx();
      t_fifo();
      t_rx();
      t_flow();
      finish_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge ref_clk);
      fails++;
      finish_test();
   end
endmodule : uifc_uart_interrupt_fifo_control_tb
